// ===== core/core_bus_pkg.sv
// Purpose: shared types and constants of the load/store bus unit
// Assumes: 16-bit core, 21-bit addresses, registers reached over APB
// Notes: register offsets are word indices; byte address is index * 4
package core_bus_pkg;

    // register indices (byte address = index * 4)
    localparam logic [17:0] IDX_BCFG = 18'h0f900;
    localparam logic [17:0] IDX_IOCFG = 18'h0f902;
    localparam logic [17:0] IDX_SZCFG0 = 18'h0f904;
    localparam logic [17:0] IDX_SZCFG1 = 18'h0f906;
    localparam logic [17:0] IDX_STATUS = 18'h0f908;
    localparam logic [17:0] IDX_INTSTK = 18'h0f90a;

    localparam logic [15:0] RST_BCFG = 16'h0007;
    localparam logic [15:0] RST_ZONE = 16'h069f;
    localparam logic [20:0] RST_INTSTK = 21'h000000;

    // field positions
    localparam int EARLY_WR_BIT = 0;
    localparam int WAIT_LSB = 0;
    localparam int HOLD_LSB = 3;
    localparam int FAST_RD_BIT = 12;

    // basic cycle lengths in clocks
    localparam logic [1:0] BASE_NREAD = 2'h2;
    localparam logic [1:0] BASE_FREAD = 2'h1;
    localparam logic [1:0] BASE_LWRITE = 2'h2;
    localparam logic [1:0] BASE_EWRITE = 2'h3;

    localparam logic [3:0] IDX_RETADDR = 4'he;
    localparam logic [3:0] IDX_PSTK = 4'hf;
    localparam logic [15:0] STACK_STEP = 16'h0002;

    typedef enum logic [2:0] {
        OP_OPERAND, OP_BRANCH, OP_LOAD, OP_STORE,
        OP_PUSH, OP_POP, OP_EXC_PUSH, OP_EXC_POP
    } op_t;

    typedef enum logic [2:0] {MD_REG, MD_IMM, MD_REL, MD_FAR, MD_ABS} mode_t;

    typedef enum logic [1:0] {Z_FLASH, Z_BOOT, Z_IO} zone_t;

    typedef struct packed {
        op_t op;
        mode_t mode;
        logic word;
        logic [3:0] rsel;
        logic [3:0] dsel;
        logic [2:0] cond;
        logic [3:0] flags;
        logic [20:0] disp;
        logic [20:0] pc;
        logic [15:0] sdata;
    } req_t;

    typedef struct packed {
        logic done;
        logic taken;
        logic [20:0] value;
    } rsp_t;

    typedef struct packed {
        logic [2:0] zone_sel;
        logic [20:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic rd;
        logic wr;
        logic hold;
    } zbus_t;

endpackage

// ===== core/core_load_store_bus_unit.sv
// Purpose: operand addressing, stacks and zone bus cycles of the core
// Assumes: one request at a time; bus_rdata valid in the last basic clock
// Notes: config registers on APB, one wait state per access
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps

module core_load_store_bus_unit #(
    parameter logic [20:0] BOOT_BASE = 21'h00e000,
    parameter logic [20:0] IO_BASE = 21'h00f000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [19:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire core_bus_pkg::req_t req,
    output logic req_ready,
    output core_bus_pkg::rsp_t rsp,
    input wire logic reg_we,
    input wire logic [3:0] reg_wsel,
    input wire logic [15:0] reg_wdata,
    output core_bus_pkg::zbus_t zbus,
    input wire logic [15:0] bus_rdata
);

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WAIT, S_ACC, S_HOLD} state_t;

    state_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt, wait_r;
    logic [15:0] gpr_r [16];
    logic [20:0] intstk_r;
    logic [15:0] bcfg_r, iocfg_r, szcfg0_r, szcfg1_r, rdat_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, req_ready_r, fast_r;
    core_bus_pkg::rsp_t rsp_r;
    core_bus_pkg::zbus_t zbus_r;
    core_bus_pkg::req_t req_r;
    logic [1:0] hold_r, base_r, zone_last_r;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] pick(input logic [15:0] d, input logic a0, input logic w);
        if (w) begin
            pick = d;
        end else begin
            pick = {8'h00, a0 ? d[15:8] : d[7:0]};
        end
    endfunction

    function automatic logic [20:0] eff_addr(input core_bus_pkg::mode_t m, input logic [15:0] lo,
                                             input logic [15:0] hi, input logic [20:0] disp);
        unique case (m)
            core_bus_pkg::MD_REL: eff_addr = {5'h00, lo} + disp;
            core_bus_pkg::MD_FAR: eff_addr = {hi[4:0], lo} + disp;
            default: eff_addr = disp;
        endcase
    endfunction

    function automatic logic cond_true(input logic [2:0] c, input logic [3:0] f);
        // flags are {n, z, l, c}
        unique case (c)
            3'h0: cond_true = f[2];
            3'h1: cond_true = !f[2];
            3'h2: cond_true = f[0];
            3'h3: cond_true = !f[0];
            3'h4: cond_true = f[1];
            3'h5: cond_true = !f[1] && !f[2];
            3'h6: cond_true = f[3];
            3'h7: cond_true = !f[3] && !f[2];
        endcase
    endfunction

    // ---------------- request decode ----------------
    logic accept, bus_op, is_wr, is_word, fast_c;
    logic [20:0] addr_c;
    logic [15:0] pstk_w, src_v, wdata_c, cfg_c;
    core_bus_pkg::zone_t zone_c;
    logic [1:0] base_c;
    logic [2:0] wait_c;
    logic [1:0] hold_c;

    assign pstk_w = gpr_r[core_bus_pkg::IDX_PSTK];
    assign src_v = gpr_r[req.rsel];
    assign accept = req_valid && req_ready_r;
    assign bus_op = req.op inside {core_bus_pkg::OP_LOAD, core_bus_pkg::OP_STORE,
                                   core_bus_pkg::OP_PUSH, core_bus_pkg::OP_POP,
                                   core_bus_pkg::OP_EXC_PUSH, core_bus_pkg::OP_EXC_POP};
    assign is_wr = req.op inside {core_bus_pkg::OP_STORE, core_bus_pkg::OP_PUSH,
                                  core_bus_pkg::OP_EXC_PUSH};
    assign is_word = req.word || !(req.op inside {core_bus_pkg::OP_LOAD, core_bus_pkg::OP_STORE});

    always_comb begin
        unique case (req.op)
            core_bus_pkg::OP_PUSH: addr_c = {5'h00, pstk_w - core_bus_pkg::STACK_STEP};
            core_bus_pkg::OP_POP: addr_c = {5'h00, pstk_w};
            core_bus_pkg::OP_EXC_PUSH: addr_c = intstk_r - {5'h00, core_bus_pkg::STACK_STEP};
            core_bus_pkg::OP_EXC_POP: addr_c = intstk_r;
            default: addr_c = eff_addr(req.mode, src_v, gpr_r[4'(req.rsel + 4'h1)], req.disp);
        endcase
    end

    always_comb begin
        if (req.op == core_bus_pkg::OP_EXC_PUSH) begin
            wdata_c = req.sdata;
        end else if (is_word) begin
            wdata_c = src_v;
        end else begin
            wdata_c = {src_v[7:0], src_v[7:0]};
        end
    end

    // zone decode and per-zone timing
    always_comb begin
        if (addr_c >= IO_BASE) begin
            zone_c = core_bus_pkg::Z_IO;
            cfg_c = iocfg_r;
        end else if (addr_c >= BOOT_BASE) begin
            zone_c = core_bus_pkg::Z_BOOT;
            cfg_c = szcfg1_r;
        end else begin
            zone_c = core_bus_pkg::Z_FLASH;
            cfg_c = szcfg0_r;
        end
        fast_c = !is_wr && zone_c != core_bus_pkg::Z_IO && cfg_c[core_bus_pkg::FAST_RD_BIT];
        if (is_wr) begin
            base_c = bcfg_r[core_bus_pkg::EARLY_WR_BIT] ? core_bus_pkg::BASE_EWRITE
                                                    : core_bus_pkg::BASE_LWRITE;
        end else begin
            base_c = fast_c ? core_bus_pkg::BASE_FREAD : core_bus_pkg::BASE_NREAD;
        end
        wait_c = fast_c ? 3'h0 : cfg_c[core_bus_pkg::WAIT_LSB +: 3];
        hold_c = fast_c ? 2'h0 : cfg_c[core_bus_pkg::HOLD_LSB +: 2];
    end

    // ---------------- bus cycle sequencing ----------------
    logic to_acc, acc_end, cyc_end;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        to_acc = 1'b0;
        acc_end = 1'b0;
        cyc_end = 1'b0;
        unique case (state_r)
            S_IDLE: begin
                if (accept && bus_op) begin
                    state_nxt = S_ADDR;
                end
            end
            S_ADDR: begin
                if (wait_r != 3'h0) begin
                    state_nxt = S_WAIT;
                    cnt_nxt = wait_r - 3'h1;
                end else begin
                    to_acc = 1'b1;
                end
            end
            S_WAIT: begin
                if (cnt_r == 3'h0) begin
                    to_acc = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            S_ACC: begin
                if (cnt_r == 3'h0) begin
                    acc_end = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            S_HOLD: begin
                if (cnt_r == 3'h0) begin
                    cyc_end = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
        endcase
        if (to_acc) begin
            if (base_r > 2'h1) begin
                state_nxt = S_ACC;
                cnt_nxt = {1'b0, base_r} - 3'h2;
            end else begin
                acc_end = 1'b1;
            end
        end
        if (acc_end) begin
            if (hold_r != 2'h0) begin
                state_nxt = S_HOLD;
                cnt_nxt = {1'b0, hold_r} - 3'h1;
            end else begin
                cyc_end = 1'b1;
            end
        end
        if (cyc_end) begin
            state_nxt = S_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            cnt_r <= 3'h0;
            req_ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            req_ready_r <= state_nxt == S_IDLE;
        end
    end

    // latch the request and the timing of the addressed zone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= '0;
            wait_r <= 3'h0;
            hold_r <= 2'h0;
            base_r <= 2'h0;
            fast_r <= 1'b0;
            zone_last_r <= 2'h0;
        end else if (accept && bus_op) begin
            req_r <= req;
            wait_r <= wait_c;
            hold_r <= hold_c;
            base_r <= base_c;
            fast_r <= fast_c;
            zone_last_r <= zone_c;
        end
    end

    // zone bus strobes stand for the whole cycle, data through hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zbus_r <= '0;
        end else if (accept && bus_op) begin
            zbus_r.zone_sel <= 3'h1 << zone_c;
            zbus_r.addr <= addr_c;
            zbus_r.wdata <= wdata_c;
            zbus_r.be <= is_word ? 2'h3 : (addr_c[0] ? 2'h2 : 2'h1);
            zbus_r.rd <= !is_wr;
            zbus_r.wr <= is_wr;
            zbus_r.hold <= 1'b0;
        end else if (cyc_end) begin
            zbus_r <= '0;
        end else if (acc_end) begin
            zbus_r.hold <= 1'b1;
        end
    end

    logic [15:0] ld_val;
    assign ld_val = (hold_r != 2'h0) ? rdat_r : pick(bus_rdata, zbus_r.addr[0], req_r.word);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdat_r <= 16'h0000;
        end else if (acc_end) begin
            rdat_r <= pick(bus_rdata, zbus_r.addr[0], req_r.word);
        end
    end

    // ---------------- register file and stacks ----------------
    logic ld_we;
    assign ld_we = cyc_end && (req_r.op == core_bus_pkg::OP_LOAD || req_r.op == core_bus_pkg::OP_POP);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                gpr_r[i] <= 16'h0000;
            end
        end else begin
            if (reg_we) begin
                gpr_r[reg_wsel] <= reg_wdata;
            end
            if (cyc_end && req_r.op == core_bus_pkg::OP_PUSH) begin
                gpr_r[core_bus_pkg::IDX_PSTK] <= pstk_w - core_bus_pkg::STACK_STEP;
            end
            if (cyc_end && req_r.op == core_bus_pkg::OP_POP) begin
                gpr_r[core_bus_pkg::IDX_PSTK] <= pstk_w + core_bus_pkg::STACK_STEP;
            end
            if (ld_we) begin
                if (req_r.word || req_r.op == core_bus_pkg::OP_POP) begin
                    gpr_r[req_r.dsel] <= ld_val;
                end else begin
                    gpr_r[req_r.dsel][7:0] <= ld_val[7:0];
                end
            end
        end
    end

    // ---------------- answer to the core ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_r <= '0;
        end else begin
            rsp_r.done <= (accept && !bus_op) || cyc_end;
            if (accept && req.op == core_bus_pkg::OP_OPERAND) begin
                rsp_r.taken <= 1'b0;
                rsp_r.value <= (req.mode == core_bus_pkg::MD_REG) ? {5'h00, src_v} : req.disp;
            end else if (accept && req.op == core_bus_pkg::OP_BRANCH) begin
                rsp_r.taken <= cond_true(req.cond, req.flags);
                rsp_r.value <= req.pc + req.disp;
            end else if (cyc_end) begin
                rsp_r.taken <= 1'b0;
                rsp_r.value <= zbus_r.wr ? zbus_r.addr : {5'h00, ld_val};
            end
        end
    end

    // ---------------- APB register slave ----------------
    logic apb_rd_ph, apb_wr;
    logic [17:0] idx;
    logic hit;
    logic [31:0] rmux;
    assign idx = paddr[19:2];
    assign apb_rd_ph = psel && penable && !pready_r;
    assign apb_wr = psel && penable && pready_r && pwrite;

    always_comb begin
        hit = 1'b1;
        unique case (idx)
            core_bus_pkg::IDX_BCFG: rmux = {16'h0000, bcfg_r};
            core_bus_pkg::IDX_IOCFG: rmux = {16'h0000, iocfg_r};
            core_bus_pkg::IDX_SZCFG0: rmux = {16'h0000, szcfg0_r};
            core_bus_pkg::IDX_SZCFG1: rmux = {16'h0000, szcfg1_r};
            core_bus_pkg::IDX_STATUS: rmux = {28'h0000000, fast_r, zone_last_r, state_r != S_IDLE};
            core_bus_pkg::IDX_INTSTK: rmux = {11'h000, intstk_r};
            default: begin
                rmux = 32'h00000000;
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= apb_rd_ph;
            pslverr_r <= apb_rd_ph && !hit;
            if (apb_rd_ph) begin
                prdata_r <= pwrite ? 32'h00000000 : rmux;
            end
        end
    end

    // reset values select normal reads and early writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcfg_r <= core_bus_pkg::RST_BCFG;
            iocfg_r <= core_bus_pkg::RST_ZONE;
            szcfg0_r <= core_bus_pkg::RST_ZONE;
            szcfg1_r <= core_bus_pkg::RST_ZONE;
        end else if (apb_wr) begin
            if (idx == core_bus_pkg::IDX_BCFG) bcfg_r <= {8'h00, pstrb[0] ? pwdata[7:0] : bcfg_r[7:0]};
            if (idx == core_bus_pkg::IDX_IOCFG) iocfg_r <= merge16(iocfg_r, pwdata, pstrb);
            if (idx == core_bus_pkg::IDX_SZCFG0) szcfg0_r <= merge16(szcfg0_r, pwdata, pstrb);
            if (idx == core_bus_pkg::IDX_SZCFG1) szcfg1_r <= merge16(szcfg1_r, pwdata, pstrb);
        end
    end

    // hardware stack moves win over a software load in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intstk_r <= core_bus_pkg::RST_INTSTK;
        end else if (cyc_end && req_r.op == core_bus_pkg::OP_EXC_PUSH) begin
            intstk_r <= intstk_r - {5'h00, core_bus_pkg::STACK_STEP};
        end else if (cyc_end && req_r.op == core_bus_pkg::OP_EXC_POP) begin
            intstk_r <= intstk_r + {5'h00, core_bus_pkg::STACK_STEP};
        end else if (apb_wr && idx == core_bus_pkg::IDX_INTSTK) begin
            intstk_r <= {pwdata[20:16], merge16(intstk_r[15:0], pwdata, pstrb)};
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign req_ready = req_ready_r;
    assign rsp = rsp_r;
    assign zbus = zbus_r;

    // ---------------- checks ----------------
    logic [3:0] len_r, exp_len_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r <= 4'h0;
            exp_len_r <= 4'h0;
        end else if (accept && bus_op) begin
            len_r <= 4'h1;
            exp_len_r <= {2'h0, base_c} + {1'b0, wait_c} + {2'h0, hold_c};
        end else if (state_r != S_IDLE) begin
            len_r <= len_r + 4'h1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    cycle_length_a: assert property (cyc_end |-> len_r == exp_len_r)
        else $error("bus cycle length wrong");
    fast_read_a: assert property (state_r == S_ADDR && fast_r |-> zbus_r.rd ##1 !zbus_r.rd)
        else $error("fast read not one clock");
    normal_read_a: assert property (state_r == S_ADDR && zbus_r.rd && !fast_r |=> zbus_r.rd)
        else $error("normal read shorter than two clocks");
    early_write_a: assert property (state_r == S_ADDR && zbus_r.wr && base_r == 2'h3 && wait_r == 3'h0
        && hold_r == 2'h0 |-> zbus_r.wr [*3] ##1 !zbus_r.wr)
        else $error("early write not three clocks");
    wait_after_addr_a: assert property (state_r == S_ADDR && wait_r != 3'h0 |=> state_r == S_WAIT)
        else $error("wait not after address");
    hold_data_a: assert property (state_r == S_HOLD |-> $stable(zbus_r.wdata) && $stable(zbus_r.addr)
        && zbus_r.hold)
        else $error("data moved during hold");
    push_decrement_a: assert property (cyc_end && req_r.op == core_bus_pkg::OP_PUSH && !reg_we
        |=> pstk_w == $past(pstk_w) - core_bus_pkg::STACK_STEP)
        else $error("push did not lower stack pointer");
    exc_push_a: assert property (state_r == S_ADDR && req_r.op == core_bus_pkg::OP_EXC_PUSH
        |-> zbus_r.wr && zbus_r.addr == intstk_r - 21'h000002)
        else $error("exception push address wrong");

    fast_read_c: cover property (state_r == S_ADDR && fast_r);
    early_wait_c: cover property (state_r == S_WAIT && zbus_r.wr && base_r == 2'h3);
    exc_pop_c: cover property (cyc_end && req_r.op == core_bus_pkg::OP_EXC_POP);

endmodule

// ===== tb/zone_mem_model.sv
// Purpose: behavioural flash, boot rom and io zones answering bus reads
// Assumes: read data is a pattern derived from the bus address
// Notes: when no read is under way the data shows the inverse of the last value
`timescale 1ns/10ps
module zone_mem_model (
    input wire logic pclk,
    input wire core_bus_pkg::zbus_t zbus,
    output logic [15:0] bus_rdata
);
    logic [15:0] last_r = 16'h0000;

    always_ff @(posedge pclk) begin
        last_r <= bus_rdata;
    end

    // idle data keeps moving so a stale sample cannot pass for a real one
    always_comb begin
        bus_rdata = (zbus.rd && zbus.zone_sel != 3'h0) ? (zbus.addr[15:0] ^ 16'ha5c3) : ~last_r;
    end
endmodule

// ===== tb/test_core_load_store_bus_unit.sv
// Purpose: self-checking bench of the load/store bus unit
// Assumes: registers reached over APB, one core request at a time
// Notes: bus length counts edges with a zone strobe high
`timescale 1ns/10ps
module test_core_load_store_bus_unit;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [3:0] pstrb = 4'h3;
    logic pready, pslverr, req_ready, err;
    logic req_valid = 1'b0;
    logic reg_we = 1'b0;
    logic [3:0] reg_wsel = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] bus_rdata;
    core_bus_pkg::req_t req = '0;
    core_bus_pkg::rsp_t rsp;
    core_bus_pkg::zbus_t zbus;
    int n_mismatch = 0;
    int checks = 0;

    always #4 pclk = ~pclk;

    core_load_store_bus_unit uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp), .reg_we(reg_we),
        .reg_wsel(reg_wsel), .reg_wdata(reg_wdata), .zbus(zbus), .bus_rdata(bus_rdata));
    zone_mem_model mem (.pclk(pclk), .zbus(zbus), .bus_rdata(bus_rdata));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setreg(input logic [3:0] sel, input logic [15:0] val);
        @(posedge pclk);
        reg_we <= 1'b1;
        reg_wsel <= sel;
        reg_wdata <= val;
        @(posedge pclk);
        reg_we <= 1'b0;
    endtask

    task automatic run(input core_bus_pkg::op_t op, input core_bus_pkg::mode_t md, input logic [20:0] dp,
        input logic [7:0] elen, input logic [20:0] ea);
        int n;
        logic [20:0] a;
        logic [2:0] z;
        logic [15:0] w;
        n = 0;
        a = '0;
        z = '0;
        w = '0;
        @(posedge pclk);
        req <= '{op: op, mode: md, word: 1'b1, rsel: 4'h5, dsel: 4'h1, cond: 3'h0, flags: 4'h0, disp: dp,
            pc: 21'h0, sdata: 16'h5a5a};
        req_valid <= 1'b1;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do begin
            @(posedge pclk);
            if ((zbus.rd | zbus.wr | zbus.hold) === 1'b1) begin
                if (n == 0) begin
                    a = zbus.addr;
                    z = zbus.zone_sel;
                    w = zbus.wdata;
                end
                n++;
            end
        end while (rsp.done !== 1'b1 && n < 40);
        check(32'(n), 32'(elen));
        check(32'(a), 32'(ea));
        check(32'(z), 32'(ea >= 21'h00f000 ? 3'h4 : ea >= 21'h00e000 ? 3'h2 : 3'h1));
        if (op == core_bus_pkg::OP_LOAD)
            check(32'(rsp.value), 32'(ea[15:0] ^ 16'ha5c3));
        if (op == core_bus_pkg::OP_STORE)
            check(32'(rsp.value), 32'(ea));
        // write data: r5 holds 0100 for store and push, the state word for exceptions
        if (op inside {core_bus_pkg::OP_STORE, core_bus_pkg::OP_PUSH, core_bus_pkg::OP_EXC_PUSH})
            check(32'(w), op == core_bus_pkg::OP_EXC_PUSH ? 32'h00005a5a : 32'h00000100);
    endtask

    // non-memory request: answered next cycle with no zone strobe
    task automatic opnd(input core_bus_pkg::op_t op, input core_bus_pkg::mode_t md, input logic [2:0] cd,
        input logic [3:0] fl, input logic exp_taken, input logic [20:0] exp_val);
        @(posedge pclk);
        req <= '{op: op, mode: md, word: 1'b1, rsel: 4'h5, dsel: 4'h1, cond: cd, flags: fl, disp: 21'h000040,
            pc: 21'h001000, sdata: 16'h0000};
        req_valid <= 1'b1;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        @(posedge pclk);
        check(32'(zbus.rd | zbus.wr), 32'h00000000);
        check(32'(rsp.done), 32'h00000001);
        check(32'(rsp.taken), 32'(exp_taken));
        check(32'(rsp.value), 32'(exp_val));
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, core_bus_pkg::IDX_BCFG, 32'h0);
        check(rd, 32'h00000007);
        apb(1'b0, core_bus_pkg::IDX_SZCFG0, 32'h0);
        check(rd, 32'h0000069f);
        apb(1'b0, 18'h0f90c, 32'h0);
        check({31'h0, err}, 32'h00000001);
        $display("test reset values done");
        setreg(4'h5, 16'h0100);
        opnd(core_bus_pkg::OP_OPERAND, core_bus_pkg::MD_REG, 3'h0, 4'h0, 1'b0, 21'h000100);
        opnd(core_bus_pkg::OP_OPERAND, core_bus_pkg::MD_IMM, 3'h0, 4'h0, 1'b0, 21'h000040);
        opnd(core_bus_pkg::OP_BRANCH, core_bus_pkg::MD_IMM, 3'h0, 4'h4, 1'b1, 21'h001040);
        opnd(core_bus_pkg::OP_BRANCH, core_bus_pkg::MD_IMM, 3'h7, 4'h8, 1'b0, 21'h001040);
        $display("test operands done");
        run(core_bus_pkg::OP_STORE, core_bus_pkg::MD_REL, 21'h000010, 8'd13, 21'h000110);
        run(core_bus_pkg::OP_LOAD, core_bus_pkg::MD_REL, 21'h00000c, 8'd12, 21'h00010c);
        apb(1'b1, core_bus_pkg::IDX_SZCFG0, 32'h0000000a);
        apb(1'b1, core_bus_pkg::IDX_BCFG, 32'h00000006);
        run(core_bus_pkg::OP_STORE, core_bus_pkg::MD_ABS, 21'h000200, 8'd5, 21'h000200);
        run(core_bus_pkg::OP_LOAD, core_bus_pkg::MD_REL, 21'h00000c, 8'd5, 21'h00010c);
        $display("test write styles done");
        apb(1'b1, core_bus_pkg::IDX_SZCFG0, 32'h0000100f);
        run(core_bus_pkg::OP_LOAD, core_bus_pkg::MD_ABS, 21'h000300, 8'd1, 21'h000300);
        apb(1'b1, core_bus_pkg::IDX_SZCFG1, 32'h00000003);
        run(core_bus_pkg::OP_LOAD, core_bus_pkg::MD_ABS, 21'h00e004, 8'd5, 21'h00e004);
        apb(1'b1, core_bus_pkg::IDX_IOCFG, 32'h00000008);
        run(core_bus_pkg::OP_LOAD, core_bus_pkg::MD_ABS, 21'h00f010, 8'd3, 21'h00f010);
        setreg(4'h6, 16'h0001);
        run(core_bus_pkg::OP_LOAD, core_bus_pkg::MD_FAR, 21'h000004, 8'd3, 21'h010104);
        $display("test zones done");
        setreg(4'hf, 16'h0200);
        run(core_bus_pkg::OP_PUSH, core_bus_pkg::MD_REG, 21'h0, 8'd10, 21'h0001fe);
        run(core_bus_pkg::OP_POP, core_bus_pkg::MD_REG, 21'h0, 8'd1, 21'h0001fe);
        apb(1'b1, core_bus_pkg::IDX_INTSTK, 32'h00000400);
        run(core_bus_pkg::OP_EXC_PUSH, core_bus_pkg::MD_REG, 21'h0, 8'd10, 21'h0003fe);
        apb(1'b0, core_bus_pkg::IDX_INTSTK, 32'h0);
        check(rd, 32'h000003fe);
        run(core_bus_pkg::OP_EXC_POP, core_bus_pkg::MD_REG, 21'h0, 8'd1, 21'h0003fe);
        apb(1'b0, core_bus_pkg::IDX_INTSTK, 32'h0);
        check(rd, 32'h00000400);
        $display("test stacks done");
        apb(1'b1, core_bus_pkg::IDX_BCFG, 32'h00000007);
        apb(1'b1, core_bus_pkg::IDX_SZCFG0, 32'h00000000);
        run(core_bus_pkg::OP_STORE, core_bus_pkg::MD_ABS, 21'h000080, 8'd3, 21'h000080);
        $display("test early write done");
        end_of_test();
    end

    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule
